// File: dhp_host_port.sv
/*
  Host command port of a 32-channel DAC: serial frame engine, parallel
  acquisition port, DAC register bank, acquisition timer, Wishbone slave.
  Assumes host pins are asynchronous; shift clock is far slower than clk_i.
*/
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
module dhp_host_port (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link
  input wire logic sync_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  // parallel port
  input wire logic interface_select_i,
  input wire logic wr_n_i,
  input wire logic [4:0] channel_address_i,
  input wire logic offset_sel_i,
  input wire logic broadcast_i,
  // acquisition status
  output logic acq_busy_o,
  output logic [5:0] acq_chan_o,
  output logic acq_all_o
);
  localparam int CW = dhp_pkg::CODE_W;

  // ==========================================================
  // pin synchronisers
  dhp_pins_if #(.W(dhp_pkg::PIN_W)) pv ();
  logic [dhp_pkg::PIN_W-1:0] pins;
  assign pins = {broadcast_i, offset_sel_i, channel_address_i, wr_n_i,
                 interface_select_i, din_i, sclk_i, sync_n_i};

  dhp_pin_sync #(.W(dhp_pkg::PIN_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pins),
    .pv(pv.src)
  );

  logic ser_en;
  logic sync_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  assign ser_en = pv.lvl[dhp_pkg::P_SEL];
  assign sync_fall = pv.fall[dhp_pkg::P_SYNC];
  assign sclk_rise = pv.rise[dhp_pkg::P_SCLK];
  // edges found by clk_i, so a gated or free-running shift clock works alike
  assign sclk_fall = pv.fall[dhp_pkg::P_SCLK];
  assign din_s = pv.lvl[dhp_pkg::P_DIN];

  // ==========================================================
  // serial frame engine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } dhp_state_t;

  dhp_state_t st_q;
  logic [4:0] cnt_q;
  logic [23:0] sh_q;
  logic [1:0] mode_q;
  logic rb_frame_q;
  logic rb_pend_q;
  logic [5:0] rb_tgt_q;
  logic [CW-1:0] rb_sh_q;
  logic dout_q;
  logic oe_q;
  logic [CW-1:0] dac_q [0:dhp_pkg::NUM_REGS-1];

  logic [23:0] sh_nx;
  logic [4:0] frame_len;
  logic ser_done;
  logic rb_last_fall;
  assign sh_nx = {sh_q[22:0], din_s};
  // length depends on mode bits held since the second bit
  assign frame_len = (mode_q == dhp_pkg::MODE_DAC) ? dhp_pkg::DAC_BITS : dhp_pkg::HDR_BITS;
  assign ser_done = ser_en && st_q == ST_SHIFT && !rb_frame_q && sclk_fall
                    && cnt_q >= dhp_pkg::MODE_CNT && (cnt_q + 5'h01) == frame_len;
  assign rb_last_fall = ser_en && st_q == ST_SHIFT && rb_frame_q && sclk_fall
                        && cnt_q == dhp_pkg::RB_LAST;

  // ==========================================================
  // command decode
  logic [9:0] hdr;
  logic [CW-1:0] cmd_code;
  logic par_go;
  logic cmd_go;
  logic [1:0] cmd_mode;
  logic cmd_bc;
  logic cmd_offs;
  logic [4:0] cmd_addr;
  logic [5:0] cmd_tgt;

  assign hdr = (mode_q == dhp_pkg::MODE_DAC) ? sh_nx[23:14] : sh_nx[9:0];
  assign cmd_code = sh_nx[CW-1:0];
  // frame select doubles as chip select of the parallel port
  assign par_go = !ser_en && pv.rise[dhp_pkg::P_WR] && !pv.lvl[dhp_pkg::P_SYNC];
  assign cmd_go = ser_done || par_go;

  always_comb begin
    if (par_go) begin
      cmd_mode = dhp_pkg::MODE_ACQ;
      cmd_bc = pv.lvl[dhp_pkg::P_BC];
      cmd_offs = pv.lvl[dhp_pkg::P_OFFS];
      cmd_addr = pv.lvl[dhp_pkg::P_ADDR +: dhp_pkg::ADDR_W];
    end else begin
      cmd_mode = hdr[dhp_pkg::HF_MODE +: 2];
      cmd_bc = hdr[dhp_pkg::HF_BC];
      cmd_offs = hdr[dhp_pkg::HF_OFFS];
      cmd_addr = hdr[dhp_pkg::HF_ADDR +: dhp_pkg::ADDR_W];
    end
    // test bit is left unused: the host keeps it low
    cmd_tgt = cmd_offs ? dhp_pkg::OFFS_CH : {1'b0, cmd_addr};
  end

  logic acq_start;
  logic acq_bc;
  logic dac_load;
  assign acq_start = cmd_go && (cmd_mode == dhp_pkg::MODE_ACQ || cmd_mode == dhp_pkg::MODE_ACQ_RB);
  assign acq_bc = cmd_bc && cmd_mode == dhp_pkg::MODE_ACQ;
  assign dac_load = ser_done && cmd_mode == dhp_pkg::MODE_DAC;

  // frame sequencing: counter cleared only from idle, so stray edges are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 24'h000000;
      mode_q <= 2'h0;
      rb_frame_q <= 1'b0;
      rb_pend_q <= 1'b0;
      rb_tgt_q <= 6'h00;
    end else if (!ser_en) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (sync_fall) begin
            st_q <= ST_SHIFT;
            cnt_q <= 5'h00;
            rb_frame_q <= rb_pend_q;
            rb_pend_q <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (sclk_fall) begin
            cnt_q <= cnt_q + 5'h01;
            if (rb_frame_q) begin
              if (cnt_q == dhp_pkg::RB_LAST) begin
                st_q <= ST_IDLE;
              end
            end else begin
              sh_q <= sh_nx;
              if (cnt_q == dhp_pkg::MODE_CNT) begin
                mode_q <= {sh_q[0], din_s};
              end
              if (ser_done) begin
                st_q <= ST_IDLE;
                if (cmd_mode == dhp_pkg::MODE_ACQ_RB || cmd_mode == dhp_pkg::MODE_RB) begin
                  rb_pend_q <= 1'b1;
                  rb_tgt_q <= cmd_tgt;
                end
              end
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // readback output: code copied at frame start, MSB first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rb_sh_q <= '0;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (!ser_en) begin
      oe_q <= 1'b0;
    end else if (st_q == ST_IDLE && sync_fall && rb_pend_q) begin
      rb_sh_q <= dac_q[rb_tgt_q];
    end else if (st_q == ST_SHIFT && rb_frame_q) begin
      if (sclk_rise) begin
        dout_q <= rb_sh_q[CW-1];
        rb_sh_q <= {rb_sh_q[CW-2:0], 1'b0};
        oe_q <= 1'b1;
      end
      if (rb_last_fall) begin
        oe_q <= 1'b0;
      end
    end
  end

  assign dout_o = dout_q;
  assign dout_oe_o = oe_q;

  // ==========================================================
  // acquisition timer stands in for the analog converter
  logic acq_busy_q;
  logic [dhp_pkg::TMR_W-1:0] acq_tmr_q;
  logic [5:0] acq_tgt_q;
  logic acq_all_q;
  logic acq_done;
  logic [CW-1:0] acq_code_q;
  assign acq_done = acq_busy_q && acq_tmr_q == '0;

  // a new command restarts the timer; the earlier one is abandoned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acq_busy_q <= 1'b0;
      acq_tmr_q <= '0;
      acq_tgt_q <= 6'h00;
      acq_all_q <= 1'b0;
    end else if (acq_start) begin
      acq_busy_q <= 1'b1;
      acq_tgt_q <= cmd_tgt;
      acq_all_q <= acq_bc;
      if (acq_bc) begin
        acq_tmr_q <= dhp_pkg::TMR_W'(dhp_pkg::BC_CYC - 1);
      end else begin
        acq_tmr_q <= dhp_pkg::TMR_W'(dhp_pkg::ACQ_CYC - 1);
      end
    end else if (acq_done) begin
      acq_busy_q <= 1'b0;
    end else if (acq_busy_q) begin
      acq_tmr_q <= acq_tmr_q - dhp_pkg::TMR_W'(1);
    end
  end

  assign acq_busy_o = acq_busy_q;
  assign acq_chan_o = acq_tgt_q;
  assign acq_all_o = acq_all_q;

  // ==========================================================
  // DAC register bank, zero at power-on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < dhp_pkg::NUM_REGS; i++) begin
        dac_q[i] <= '0;
      end
    end else begin
      if (acq_done) begin
        if (acq_all_q) begin
          for (int i = 0; i < dhp_pkg::NUM_CH; i++) begin
            dac_q[i] <= acq_code_q;
          end
        end else begin
          dac_q[acq_tgt_q] <= acq_code_q;
        end
      end
      // direct load wins over a finishing acquisition in the same cycle
      if (dac_load) begin
        if (cmd_bc) begin
          for (int i = 0; i < dhp_pkg::NUM_CH; i++) begin
            dac_q[i] <= {CW{cmd_code[0]}};
          end
        end else begin
          dac_q[cmd_tgt] <= cmd_code;
        end
      end
    end
  end

  // ==========================================================
  // wishbone slave: one wait state, unmapped reads return zero
  logic ack_q;
  logic [31:0] dat_q;
  logic [5:0] rb_sel_q;
  logic [1:0] last_mode_q;
  logic [5:0] last_tgt_q;
  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_mode_q <= 2'h0;
      last_tgt_q <= 6'h00;
    end else if (cmd_go) begin
      last_mode_q <= cmd_mode;
      last_tgt_q <= cmd_tgt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      acq_code_q <= dhp_pkg::ACQ_CODE_RST;
      rb_sel_q <= 6'h00;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        dat_q <= 32'h00000000;
        if (wb_we_i) begin
          if (wb_adr_i == dhp_pkg::REG_ACQ_CODE) begin
            if (wb_sel_i[0]) begin
              acq_code_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              acq_code_q[CW-1:8] <= wb_dat_i[CW-1:8];
            end
          end
          if (wb_adr_i == dhp_pkg::REG_RB_SEL && wb_sel_i[0]) begin
            rb_sel_q <= wb_dat_i[5:0];
          end
        end else begin
          case (wb_adr_i)
            dhp_pkg::REG_ACQ_CODE: begin
              dat_q <= {18'h0, acq_code_q};
            end
            dhp_pkg::REG_STATUS: begin
              dat_q <= {21'h0, last_tgt_q, ser_en, last_mode_q, rb_pend_q, acq_busy_q};
            end
            dhp_pkg::REG_RB_SEL: begin
              dat_q <= {26'h0, rb_sel_q};
            end
            dhp_pkg::REG_RB_DATA: begin
              if (rb_sel_q < 6'(dhp_pkg::NUM_REGS)) begin
                dat_q <= {18'h0, dac_q[rb_sel_q]};
              end
            end
            default: begin
              dat_q <= 32'h00000000;
            end
          endcase
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ==========================================================
  // assertions
  localparam int AST_ACQ_LIM = dhp_pkg::ACQ_CYC + 1;
  localparam int AST_BC_LIM = dhp_pkg::BC_CYC + 1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACQ_TIME: assert property (acq_start && !acq_bc |->
    ##[1:AST_ACQ_LIM] (!acq_busy_q || acq_start))
    else $error("single acquisition overran its time");
  AST_BC_TIME: assert property (acq_start && acq_bc |=> acq_busy_q [*8]
    ##[1:AST_BC_LIM] (!acq_busy_q || acq_start))
    else $error("broadcast acquisition timing wrong");
  AST_SER_OFF: assert property (!ser_en |=> st_q == ST_IDLE && !dout_oe_o)
    else $error("serial port active while parallel selected");
  AST_PAR_ACQ: assert property (par_go |=> acq_busy_q && acq_chan_o == $past(cmd_tgt))
    else $error("parallel strobe did not start acquisition");
  AST_OFFS_TGT: assert property (cmd_go && cmd_offs |-> cmd_tgt == dhp_pkg::OFFS_CH)
    else $error("offset select did not target offset channel");
  AST_DAC_ONLY: assert property (dac_load |-> ser_done && cmd_mode == dhp_pkg::MODE_DAC)
    else $error("register loaded outside direct-load mode");
  AST_SYNC_IGN: assert property (st_q == ST_SHIFT && ser_en && !sclk_fall
    |=> st_q == ST_SHIFT && cnt_q == $past(cnt_q))
    else $error("frame select edge disturbed a running word");
  AST_DONE_IGN: assert property (st_q == ST_IDLE && !sync_fall |=> $stable(sh_q)
    && st_q == ST_IDLE)
    else $error("clock accepted after word completed");
  AST_DOUT_ON: assert property (st_q == ST_SHIFT && rb_frame_q && ser_en && sclk_rise
    |=> dout_oe_o && dout_o == $past(rb_sh_q[CW-1]))
    else $error("readback bit not driven on rising clock");
  AST_DOUT_OFF: assert property (rb_last_fall |=> !dout_oe_o && st_q == ST_IDLE)
    else $error("output not released on fourteenth fall");
  AST_RB_DIN: assert property (st_q == ST_SHIFT && rb_frame_q |=> $stable(sh_q))
    else $error("input sampled during readback");
  AST_HIZ: assert property (!(st_q == ST_SHIFT && rb_frame_q) |=> !dout_oe_o)
    else $error("output driven outside readback word");

  COV_DAC: cover property (dac_load && !cmd_bc);
  COV_RB: cover property (rb_last_fall);
  COV_PAR: cover property (par_go ##1 acq_busy_q);
  COV_BC: cover property (acq_start && acq_bc);
endmodule

// File: dhp_pkg.sv
/*
  Constants, field layouts and register map of the multichannel DAC host port.
  Assumes a 50 MHz system clock and a host that keeps its own framing rules.
*/
// Behaviour
// - acquire-and-readback: acquire within 16 us, then next frame shifts out 14-bit code
// - readback-only: no acquisition, next frame shifts out 14-bit code
// - interface select high enables serial port, low enables parallel port
// - serial output bit changes on each rising shift clock edge
// - direct-load broadcast loads all zeros or all ones into all 32 registers
// - acquisition broadcast makes all 32 channels acquire together, about 45 us
// - offset select bit targets offset channel and ignores address bits
// - five-bit channel address, MSB first, selects one of 32 channels
// - 14-bit code written into the register only in direct-load mode
// - serial port works with continuous or burst host clock
// - frame select fall clears counter; further edges ignored until word done
// - after the word's bit count, clocks ignored until a fresh frame fall
// - readback output enabled on first rise, released on fourteenth fall
// - input sampled on each falling clock; ignored during readback words
// - parallel mode, acquisition only, address captured on write strobe rise
// - parallel offset select pin targets offset channel, address ignored
// - parallel broadcast pin makes all 32 channels acquire, about 45 us
// - frame select pin doubles as parallel chip select, active low
// - first two bits select mode: acquire, direct load, acquire-readback, readback
// - direct-load write is 24 bits: 10-bit header then 14-bit code
// - acquisition command is a 10-bit header only, MSB first
package dhp_pkg;
  // ==========================================================
  // word geometry
  localparam int CODE_W = 14;
  localparam int ADDR_W = 5;
  localparam int NUM_CH = 32;
  localparam int NUM_REGS = NUM_CH + 1;
  localparam logic [5:0] OFFS_CH = 6'h20;
  localparam logic [4:0] HDR_BITS = 5'h0A;
  localparam logic [4:0] DAC_BITS = 5'h18;
  localparam logic [4:0] RB_LAST = 5'h0D;
  localparam logic [4:0] MODE_CNT = 5'h01;
  // header field positions
  localparam int HF_MODE = 8;
  localparam int HF_BC = 7;
  localparam int HF_OFFS = 6;
  localparam int HF_TEST = 5;
  localparam int HF_ADDR = 0;
  // ==========================================================
  // modes
  typedef enum logic [1:0] {
    MODE_ACQ = 2'h0,
    MODE_DAC = 2'h1,
    MODE_ACQ_RB = 2'h2,
    MODE_RB = 2'h3
  } dhp_mode_t;
  // ==========================================================
  // timing
  localparam int CLK_NS = 20;
  localparam int ACQ_MAX_NS = 16000;
  localparam int BC_TYP_NS = 45000;
  localparam int ACQ_CYC = ACQ_MAX_NS / CLK_NS;
  localparam int BC_CYC = BC_TYP_NS / CLK_NS;
  localparam int TMR_W = 12;
  // ==========================================================
  // pin vector indices
  localparam int PIN_W = 12;
  localparam int P_SYNC = 0;
  localparam int P_SCLK = 1;
  localparam int P_DIN = 2;
  localparam int P_SEL = 3;
  localparam int P_WR = 4;
  localparam int P_ADDR = 5;
  localparam int P_OFFS = 10;
  localparam int P_BC = 11;
  // ==========================================================
  // register map
  localparam logic [7:0] REG_ACQ_CODE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RB_SEL = 8'h08;
  localparam logic [7:0] REG_RB_DATA = 8'h0C;
  localparam logic [CODE_W-1:0] ACQ_CODE_RST = 14'h0000;
endpackage

// File: dhp_pins_if.sv
/*
  Interface carrying synchronised pin levels and their edges.
  Assumes one clock domain shared by both modports.
*/
`timescale 1ns/10ps
interface dhp_pins_if #(parameter int W = 1);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// File: dhp_pin_sync.sv
/*
  Two-flop synchroniser with edge detection for a vector of pins.
  Assumes pins are asynchronous to clk_i.
*/
`timescale 1ns/10ps
module dhp_pin_sync #(
  parameter int W = 1
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // pins
  input wire logic [W-1:0] pin_i,
  // synchronised view
  dhp_pins_if.src pv
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pv.lvl = sync_q;
  assign pv.rise = sync_q & ~prev_q;
  assign pv.fall = ~sync_q & prev_q;
endmodule

// File: dhp_host_model.sv
/*
  Host serial master model: frames words onto the link and reads words back.
  Assumes clk_i is the bench clock; one link clock period is 8 clk_i periods.
*/
`timescale 1ns/10ps
module dhp_host_model (
  // bench clock
  input wire logic clk_i,
  // link pins
  output logic sync_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  // ==========================================================
  // wire level
  // no pull on the data line: once released it shows the inverse of its last bit
  logic last_q = 1'b0;
  logic line;
  assign line = dout_oe_i ? dout_i : ~last_q;
  always @(posedge clk_i) begin
    if (dout_oe_i) begin
      last_q <= dout_i;
    end
  end
  initial begin
    sync_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // ==========================================================
  // framing
  task automatic sel_lvl(input logic v);
    @(posedge clk_i);
    sync_n_o <= v;
  endtask
  // n bits of w from bit 23 down; g bounces select mid-word; x extra clocks
  task automatic frame(input int n, input logic [23:0] w, input bit g, input int x,
                       output logic [13:0] rx);
    rx = 14'h0000;
    @(posedge clk_i);
    sync_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int k = 0; k < n + x; k++) begin
      sclk_o <= 1'b1;
      din_o <= (k < n) ? w[23-k] : ~din_o;  // msb first
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      if (k < 14) begin
        rx = {rx[12:0], line};
      end
      if (g && k == 5) begin
        sync_n_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        sync_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
      end else begin
        repeat (4) @(posedge clk_i);
      end
    end
    // link clock stands still between frames
    sync_n_o <= 1'b1;
    din_o <= ~din_o;
    repeat (24) @(posedge clk_i);  // gap above 400 ns
  endtask
endmodule

// File: tb.sv
/*
  Self-checking bench for the DAC host port: register tasks and link frames.
  Assumes the host model drives the link and the design acks in one cycle.
*/
`timescale 1ns/10ps
module tb;
  // ==========================================================
  // signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sync_n, sclk, din, dout_o, dout_oe_o;
  logic if_sel = 1'b1;
  logic wr_n = 1'b1;
  logic [4:0] par_adr = 5'h00;
  logic par_offs = 1'b0;
  logic par_bc = 1'b0;
  logic acq_busy_o, acq_all_o;
  logic [5:0] acq_chan_o;
  logic [13:0] rx;
  logic [31:0] q;
  int errors = 0;
  int check_count = 0;
  int n;
  always #10 clk_i = ~clk_i;
  dhp_host_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_n_i(sync_n), .sclk_i(sclk),
    .din_i(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .interface_select_i(if_sel),
    .wr_n_i(wr_n), .channel_address_i(par_adr), .offset_sel_i(par_offs),
    .broadcast_i(par_bc), .acq_busy_o(acq_busy_o), .acq_chan_o(acq_chan_o),
    .acq_all_o(acq_all_o));
  dhp_host_model i_host (.clk_i(clk_i), .sync_n_o(sync_n), .sclk_o(sclk), .din_o(din),
    .dout_i(dout_o), .dout_oe_i(dout_oe_o));
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk(t < 20, 32'h1, "ack wait");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h00000000, 4'hF);
    chk(q, e, "reg read");
  endtask
  task automatic rbk(input logic [5:0] c, input logic [13:0] e);
    wb(1'b1, dhp_pkg::REG_RB_SEL, {26'h0, c}, 4'h1);
    rd(dhp_pkg::REG_RB_DATA, {18'h0, e});
  endtask
  function automatic logic [23:0] hdr(input logic [1:0] m, input logic b, input logic o,
                                      input logic [4:0] a, input logic [13:0] c);
    return {m, b, o, 1'b0, a, c};  // test bit low
  endfunction
  task automatic idle();
    n = 0;
    while (acq_busy_o === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic pwr(input logic [4:0] a, input logic o, input logic b);
    @(posedge clk_i);
    par_adr <= a;
    par_offs <= o;
    par_bc <= b;
    wr_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog: whole run is near 10100 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    $display("BAD %0t watchdog", $time);
    print_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(dhp_pkg::REG_STATUS, 32'h00000010);
    wb(1'b1, dhp_pkg::REG_STATUS, 32'hFFFFFFFF, 4'hF);
    wb(1'b1, 8'h40, 32'hFFFFFFFF, 4'hF);
    rd(dhp_pkg::REG_STATUS, 32'h00000010);
    rd(8'h40, 32'h00000000);
    rd(dhp_pkg::REG_ACQ_CODE, 32'h00000000);
    rbk(6'h20, 14'h0000);
    tdone("reset");
    i_host.frame(24, hdr(2'h1, 1'b0, 1'b0, 5'h00, 14'h2A5C), 1'b1, 0, rx);
    i_host.frame(24, hdr(2'h1, 1'b0, 1'b0, 5'h06, 14'h15A3), 1'b0, 0, rx);
    i_host.frame(24, hdr(2'h1, 1'b0, 1'b1, 5'h03, 14'h3C01), 1'b0, 0, rx);
    rbk(6'h00, 14'h2A5C);
    rbk(6'h06, 14'h15A3);
    rbk(6'h0C, 14'h0000);
    rbk(6'h03, 14'h0000);
    rbk(6'h20, 14'h3C01);
    tdone("direct load");
    i_host.frame(10, hdr(2'h3, 1'b0, 1'b0, 5'h06, 14'h0000), 1'b0, 0, rx);
    chk(acq_busy_o, 1'b0, "no acquisition");
    i_host.frame(14, 24'hFFFFFF, 1'b0, 3, rx);
    chk({18'h0, rx}, 14'h15A3, "readback ch6");
    chk(dout_oe_o, 1'b0, "released");
    i_host.frame(10, hdr(2'h3, 1'b0, 1'b1, 5'h06, 14'h0000), 1'b0, 0, rx);
    i_host.frame(14, 24'h000000, 1'b0, 0, rx);
    chk({18'h0, rx}, 14'h3C01, "readback offset");
    tdone("readback");
    for (int f = 0; f < 2; f++) begin
      i_host.frame(24, hdr(2'h1, 1'b1, 1'b0, 5'h00, f ? 14'h3FFE : 14'h0001), 1'b0, 0, rx);
      rbk(6'h00, f ? 14'h0000 : 14'h3FFF);
      rbk(6'h1F, f ? 14'h0000 : 14'h3FFF);
    end
    rbk(6'h20, 14'h3C01);
    tdone("fill");
    wb(1'b1, dhp_pkg::REG_ACQ_CODE, 32'h00001234, 4'h3);
    wb(1'b1, dhp_pkg::REG_ACQ_CODE, 32'h00003FFF, 4'h1);
    rd(dhp_pkg::REG_ACQ_CODE, 32'h000012FF);
    i_host.frame(24, hdr(2'h0, 1'b0, 1'b0, 5'h07, 14'h0F0F), 1'b0, 0, rx);
    chk({acq_busy_o, acq_all_o, acq_chan_o}, 8'h87, "acq start");
    idle();
    chk(n > dhp_pkg::ACQ_CYC - 200 && n < dhp_pkg::ACQ_CYC, 32'h1, "acq time");
    rbk(6'h07, 14'h12FF);
    wb(1'b1, dhp_pkg::REG_ACQ_CODE, 32'h00002DB6, 4'hF);
    i_host.frame(10, hdr(2'h2, 1'b0, 1'b0, 5'h0C, 14'h0000), 1'b0, 0, rx);
    chk(acq_chan_o, 6'h0C, "acq rb target");
    idle();
    i_host.frame(14, 24'hFFFFFF, 1'b0, 0, rx);
    chk({18'h0, rx}, 14'h2DB6, "acq readback");
    tdone("acquire");
    i_host.frame(10, hdr(2'h0, 1'b1, 1'b0, 5'h00, 14'h0000), 1'b0, 0, rx);
    chk(acq_all_o, 1'b1, "all start");
    idle();
    chk(n > dhp_pkg::BC_CYC - 200 && n < dhp_pkg::BC_CYC, 32'h1, "all time");
    rbk(6'h1F, 14'h2DB6);
    rbk(6'h20, 14'h3C01);
    tdone("broadcast");
    i_host.sel_lvl(1'b0);
    if_sel <= 1'b0;
    repeat (4) @(posedge clk_i);
    pwr(5'h09, 1'b0, 1'b0);
    chk({acq_busy_o, acq_all_o, acq_chan_o}, 8'h89, "par start");
    idle();
    rbk(6'h09, 14'h2DB6);
    pwr(5'h09, 1'b1, 1'b0);
    chk(acq_chan_o, 6'h20, "par offset");
    idle();
    pwr(5'h00, 1'b0, 1'b1);
    chk(acq_all_o, 1'b1, "par all");
    idle();
    i_host.sel_lvl(1'b1);
    pwr(5'h0A, 1'b0, 1'b0);
    chk(acq_busy_o, 1'b0, "deselected");
    i_host.frame(24, hdr(2'h1, 1'b0, 1'b0, 5'h09, 14'h0555), 1'b0, 0, rx);
    rbk(6'h09, 14'h2DB6);
    wb(1'b0, dhp_pkg::REG_STATUS, 32'h00000000, 4'hF);
    chk(q[4], 1'b0, "parallel selected");
    tdone("parallel");
    print_verdict();
  end
endmodule
